// ---- hdl/dbi_bridge.sv ----
// Purpose: bus bridge that turns decorated stores into field inserts
// Assumes: one master, one slave side, one clock, AHB-lite signalling
// Notes: one transfer at a time; plain transfers pass unchanged
//
// Behaviour
// - Write with address bit 28 means insert
// - Bits 30:29 pick SRAM_U or peripheral space
// - Field lsb from address bits 27:23
// - Width minus one from address bits 22:19
// - Only bits 18:0 form the offset
// - Slave address is decorated address masked
// - Mask of w+1 ones shifted by lsb
// - Byte, halfword and word containers supported
// - Field bits beyond container are dropped
// - Read and write-back are one indivisible pair
// - First cycle turns master write into read
// - Third cycle reissues address as write
// - Read data merged and registered
// - Fourth cycle drives merged data out
// - Slave wait states stall master equally
`timescale 1ns/1ps
`default_nettype none

module dbi_bridge
  import dbi_pkg::*;
(
  input wire logic CLOCK_IN,
  input wire logic SRST_IN,
  input wire logic CE_IN,
  input wire logic [31:0] M_HADDR_IN,
  input wire logic [1:0] M_HTRANS_IN,
  input wire logic M_HWRITE_IN,
  input wire logic [2:0] M_HSIZE_IN,
  input wire logic [3:0] M_HPROT_IN,
  input wire logic [31:0] M_HWDATA_IN,
  input wire logic M_HREADY_IN,
  output var logic [31:0] M_HRDATA_OUT,
  output var logic M_HREADYOUT_OUT,
  output var logic M_HRESP_OUT,
  output var logic [31:0] S_HADDR_OUT,
  output var logic [1:0] S_HTRANS_OUT,
  output var logic S_HWRITE_OUT,
  output var logic [2:0] S_HSIZE_OUT,
  output var logic [3:0] S_HPROT_OUT,
  output var logic [31:0] S_HWDATA_OUT,
  input wire logic [31:0] S_HRDATA_IN,
  input wire logic S_HREADY_IN,
  input wire logic S_HRESP_IN
);

  dbi_state_type state_reg, state_next; // Sequencer state
  logic [31:0] addr_reg, addr_next; // Decorated address as taken
  logic [2:0] size_reg, size_next; // Transfer size as taken
  logic write_reg, write_next; // Master direction as taken
  logic ins_reg, ins_next; // Transfer is a field insert
  logic [31:0] wdata_reg, wdata_next; // Field operand from the master
  logic [31:0] m_hrdata_reg, m_hrdata_next; // Read data to master
  logic m_hready_reg, m_hready_next; // Ready to master
  logic m_hresp_reg, m_hresp_next; // Error to master
  logic [31:0] s_haddr_reg, s_haddr_next; // Slave address
  logic [1:0] s_htrans_reg, s_htrans_next; // Slave transfer type
  logic s_hwrite_reg, s_hwrite_next; // Slave direction
  logic [2:0] s_hsize_reg, s_hsize_next; // Slave size
  logic [3:0] s_hprot_reg, s_hprot_next; // Slave protection
  logic [31:0] s_hwdata_reg, s_hwdata_next; // Slave write data
  logic take; // Master address phase accepted now
  logic region_ok; // Address lies in a decorated region
  logic is_ins; // Incoming transfer decodes as insert
  logic [31:0] merge_data; // Merged container, lane-replicated

  // Decode the decoration of the incoming address
  always_comb
  begin
    take = M_HREADY_IN && M_HTRANS_IN[HTRANS_ACTIVE_BIT];
    // Upper SRAM or peripheral space only
    region_ok = !M_HADDR_IN[TOP_BIT] &&
      ((M_HADDR_IN[REGION_HI:REGION_LO] == REGION_SRAM_U) ||
       (M_HADDR_IN[REGION_HI:REGION_LO] == REGION_PERIPH));
    // Write with the insert flag set
    is_ins = M_HWRITE_IN && M_HADDR_IN[INS_FLAG_BIT] && region_ok;
  end

  // Field merge of read data and the held operand
  dbi_merge u_merge (
    .rdata_in(S_HRDATA_IN),
    .wdata_in(wdata_reg),
    .lsb_in(addr_reg[LSB_HI:LSB_LO]),
    .wm1_in(addr_reg[WM1_HI:WM1_LO]),
    .size_in(size_reg),
    .lane_in(addr_reg[LANE_HI:LANE_LO]),
    .merged_out(merge_data)
  );

  // Next-state logic of the sequencer and both bus sides
  always_comb
  begin
    state_next = state_reg;
    addr_next = addr_reg;
    size_next = size_reg;
    write_next = write_reg;
    ins_next = ins_reg;
    wdata_next = wdata_reg;
    m_hrdata_next = m_hrdata_reg;
    m_hready_next = m_hready_reg;
    m_hresp_next = m_hresp_reg;
    s_haddr_next = s_haddr_reg;
    s_htrans_next = s_htrans_reg;
    s_hwrite_next = s_hwrite_reg;
    s_hsize_next = s_hsize_reg;
    s_hprot_next = s_hprot_reg;
    s_hwdata_next = s_hwdata_reg;
    case (state_reg)
      // Waiting for a master address phase
      ST_IDLE:
      begin
        m_hresp_next = 1'b0;
        s_htrans_next = HTRANS_IDLE;
        if (take)
        begin
          // Capture address and attributes
          addr_next = M_HADDR_IN;
          size_next = M_HSIZE_IN;
          write_next = M_HWRITE_IN;
          ins_next = is_ins;
          m_hready_next = 1'b0;
          s_htrans_next = HTRANS_NONSEQ;
          s_hsize_next = M_HSIZE_IN;
          s_hprot_next = M_HPROT_IN;
          if (is_ins)
          begin
            // Decoration removed, offset is bits 18:0
            s_haddr_next = M_HADDR_IN & REAL_ADDR_MASK;
            // Master write becomes a slave read
            s_hwrite_next = 1'b0;
          end
          else
          begin
            // Untouched forward of any other access
            s_haddr_next = M_HADDR_IN;
            s_hwrite_next = M_HWRITE_IN;
          end
          state_next = ST_ADDR;
        end
      end
      // Slave address phase on the bus; master data now valid
      ST_ADDR:
      begin
        s_htrans_next = HTRANS_IDLE;
        wdata_next = M_HWDATA_IN;
        if (ins_reg)
        begin
          state_next = ST_INS_RD;
        end
        else
        begin
          s_hwdata_next = M_HWDATA_IN;
          state_next = ST_PASS;
        end
      end
      // Plain data phase; waits reach the master
      ST_PASS:
      begin
        if (S_HREADY_IN)
        begin
          m_hrdata_next = write_reg ? m_hrdata_reg : S_HRDATA_IN;
          if (S_HRESP_IN)
          begin
            m_hresp_next = 1'b1;
            state_next = ST_ERR;
          end
          else
          begin
            m_hready_next = 1'b1;
            state_next = ST_IDLE;
          end
        end
      end
      // Read data phase of the insert
      ST_INS_RD:
      begin
        if (S_HREADY_IN)
        begin
          if (S_HRESP_IN)
          begin
            // Failed read: no write-back, error to master
            m_hresp_next = 1'b1;
            state_next = ST_ERR;
          end
          else
          begin
            s_hwdata_next = merge_data;
            // Same location reissued as a write
            s_htrans_next = HTRANS_NONSEQ;
            s_hwrite_next = 1'b1;
            state_next = ST_INS_WA;
          end
        end
      end
      // Write address phase; merged data already held
      ST_INS_WA:
      begin
        s_htrans_next = HTRANS_IDLE;
        state_next = ST_INS_WD;
      end
      // Write data phase drives merged data
      ST_INS_WD:
      begin
        if (S_HREADY_IN)
        begin
          if (S_HRESP_IN)
          begin
            m_hresp_next = 1'b1;
            state_next = ST_ERR;
          end
          else
          begin
            m_hready_next = 1'b1;
            state_next = ST_IDLE;
          end
        end
      end
      // First cycle of the two-cycle error answer
      ST_ERR:
      begin
        m_hready_next = 1'b1;
        state_next = ST_IDLE;
      end
      default:
      begin
        state_next = ST_IDLE;
        m_hready_next = 1'b1;
        s_htrans_next = HTRANS_IDLE;
      end
    endcase
  end

  // State registers; synchronous reset wins, otherwise clock enable low freezes everything
  always_ff @(posedge CLOCK_IN)
  begin
    if (SRST_IN)
    begin
      state_reg <= ST_IDLE;
      addr_reg <= WORD_ZERO;
      size_reg <= PROT_ZERO3;
      write_reg <= 1'b0;
      ins_reg <= 1'b0;
      wdata_reg <= WORD_ZERO;
      m_hrdata_reg <= WORD_ZERO;
      m_hready_reg <= 1'b1;
      m_hresp_reg <= 1'b0;
      s_haddr_reg <= WORD_ZERO;
      s_htrans_reg <= HTRANS_IDLE;
      s_hwrite_reg <= 1'b0;
      s_hsize_reg <= PROT_ZERO3;
      s_hprot_reg <= PROT_RESET;
      s_hwdata_reg <= WORD_ZERO;
    end
    else if (CE_IN)
    begin
      state_reg <= state_next;
      addr_reg <= addr_next;
      size_reg <= size_next;
      write_reg <= write_next;
      ins_reg <= ins_next;
      wdata_reg <= wdata_next;
      m_hrdata_reg <= m_hrdata_next;
      m_hready_reg <= m_hready_next;
      m_hresp_reg <= m_hresp_next;
      s_haddr_reg <= s_haddr_next;
      s_htrans_reg <= s_htrans_next;
      s_hwrite_reg <= s_hwrite_next;
      s_hsize_reg <= s_hsize_next;
      s_hprot_reg <= s_hprot_next;
      s_hwdata_reg <= s_hwdata_next;
    end
  end

  // Outputs come straight from registers
  assign M_HRDATA_OUT = m_hrdata_reg;
  assign M_HREADYOUT_OUT = m_hready_reg;
  assign M_HRESP_OUT = m_hresp_reg;
  assign S_HADDR_OUT = s_haddr_reg;
  assign S_HTRANS_OUT = s_htrans_reg;
  assign S_HWRITE_OUT = s_hwrite_reg;
  assign S_HSIZE_OUT = s_hsize_reg;
  assign S_HPROT_OUT = s_hprot_reg;
  assign S_HWDATA_OUT = s_hwdata_reg;

  // Checks on the sequencer and both bus sides
  default clocking cb @(posedge CLOCK_IN);
  endclocking
  default disable iff (SRST_IN);

  a_insert_decode: assert property (
    (CE_IN && state_reg == ST_IDLE && take && M_HWRITE_IN && M_HADDR_IN[INS_FLAG_BIT] && region_ok)
    |=> ins_reg && state_reg == ST_ADDR)
    else $error("decorated write not taken as insert");

  a_region_gate: assert property (
    (CE_IN && state_reg == ST_IDLE && take && !region_ok) |=> !ins_reg)
    else $error("insert decoded outside decorated regions");

  a_write_to_read: assert property (
    (CE_IN && state_reg == ST_IDLE && take && is_ins)
    |=> S_HTRANS_OUT == HTRANS_NONSEQ && !S_HWRITE_OUT && !M_HREADYOUT_OUT)
    else $error("insert did not start with a slave read");

  a_real_address: assert property (
    (ins_reg && S_HTRANS_OUT == HTRANS_NONSEQ) |-> S_HADDR_OUT == (addr_reg & REAL_ADDR_MASK))
    else $error("slave address not stripped of decoration");

  a_write_reissue: assert property (
    (state_reg == ST_INS_WA) |-> S_HWRITE_OUT && S_HTRANS_OUT == HTRANS_NONSEQ && S_HADDR_OUT == $past(S_HADDR_OUT))
    else $error("write-back not reissued to the same address");

  a_merge_capture: assert property (
    (CE_IN && state_reg == ST_INS_RD && S_HREADY_IN && !S_HRESP_IN) |=> S_HWDATA_OUT == $past(merge_data))
    else $error("merged data not registered at read completion");

  a_merge_held: assert property (
    (state_reg == ST_INS_WA) ##1 (state_reg == ST_INS_WD) [*2] |-> $stable(S_HWDATA_OUT))
    else $error("write data moved during write-back");

  a_atomic_pair: assert property (
    (state_reg inside {ST_INS_RD, ST_INS_WA, ST_INS_WD}) |-> !M_HREADYOUT_OUT && S_HADDR_OUT == (addr_reg & REAL_ADDR_MASK))
    else $error("master released or address changed inside insert");

  a_wait_stall: assert property (
    (CE_IN && state_reg inside {ST_PASS, ST_INS_RD, ST_INS_WD} && !S_HREADY_IN)
    |=> state_reg == $past(state_reg) && !M_HREADYOUT_OUT)
    else $error("slave wait state not passed to master");

  a_plain_forward: assert property (
    (CE_IN && state_reg == ST_IDLE && take && !is_ins)
    |=> S_HADDR_OUT == $past(M_HADDR_IN) && S_HWRITE_OUT == $past(M_HWRITE_IN))
    else $error("plain access altered on its way");

  c_insert_done: cover property ((state_reg == ST_INS_WD && S_HREADY_IN && !S_HRESP_IN) ##1 M_HREADYOUT_OUT);
  c_insert_waited: cover property ((state_reg == ST_INS_RD && !S_HREADY_IN) ##1 (state_reg == ST_INS_RD));
  c_plain_read: cover property ((state_reg == ST_PASS && !write_reg && S_HREADY_IN) ##1 M_HREADYOUT_OUT);
  c_error_answer: cover property (state_reg == ST_ERR);

endmodule : dbi_bridge

`default_nettype wire

// ---- hdl/dbi_pkg.sv ----
// Purpose: shared constants and types for the field insert bridge
// Assumes: AHB-lite style 32-bit buses, one clock
// Notes: decoration field positions and bus encodings live here
`default_nettype none

package dbi_pkg;

  // Decoration fields of the incoming address
  localparam int unsigned TOP_BIT = 31;
  localparam int unsigned REGION_HI = 30;
  localparam int unsigned REGION_LO = 29;
  localparam int unsigned INS_FLAG_BIT = 28;
  localparam int unsigned LSB_HI = 27;
  localparam int unsigned LSB_LO = 23;
  localparam int unsigned WM1_HI = 22;
  localparam int unsigned WM1_LO = 19;
  localparam int unsigned LANE_HI = 1;
  localparam int unsigned LANE_LO = 0;

  // Region codes in address bits 30:29
  localparam logic [1:0] REGION_SRAM_U = 2'h1;
  localparam logic [1:0] REGION_PERIPH = 2'h2;

  // Strips the decoration, keeps region and 19-bit offset
  localparam logic [31:0] REAL_ADDR_MASK = 32'he007ffff;

  // Bus encodings
  localparam logic [1:0] HTRANS_IDLE = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam int unsigned HTRANS_ACTIVE_BIT = 1;
  localparam logic [2:0] HSIZE_BYTE = 3'h0;
  localparam logic [2:0] HSIZE_HALF = 3'h1;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // Container masks per transfer size
  localparam logic [31:0] CONT_MASK_BYTE = 32'h000000ff;
  localparam logic [31:0] CONT_MASK_HALF = 32'h0000ffff;
  localparam logic [31:0] CONT_MASK_WORD = 32'hffffffff;

  // Reset values
  localparam logic [31:0] WORD_ZERO = 32'h00000000;
  localparam logic [2:0] PROT_ZERO3 = 3'h0;
  localparam logic [3:0] PROT_RESET = 4'h0;

  // Bridge sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_PASS,
    ST_INS_RD,
    ST_INS_WA,
    ST_INS_WD,
    ST_ERR
  } dbi_state_type;

endpackage : dbi_pkg

`default_nettype wire

// ---- hdl/dbi_merge.sv ----
// Purpose: field mask and merge for one insert container
// Assumes: write data already right-aligned and lane-replicated
// Notes: purely combinational; result is lane-replicated again
`timescale 1ns/1ps
`default_nettype none

module dbi_merge
  import dbi_pkg::*;
(
  input wire logic [31:0] rdata_in,
  input wire logic [31:0] wdata_in,
  input wire logic [4:0] lsb_in,
  input wire logic [3:0] wm1_in,
  input wire logic [2:0] size_in,
  input wire logic [1:0] lane_in,
  output logic [31:0] merged_out
);

  logic [4:0] shamt; // Lane offset of the container in bits
  logic [31:0] cont_rd; // Read data moved to the low container
  logic [31:0] cont_mask; // Bits that belong to the container
  logic [16:0] ones; // Field width worth of ones
  logic [47:0] wide_mask; // Field ones at their position
  logic [31:0] mask; // Field mask clipped to the container
  logic [31:0] merged; // Container after the insert

  // Form mask and merge the field into the read container
  always_comb
  begin
    shamt = 5'h00;
    cont_mask = CONT_MASK_WORD;
    // Container size follows the originating transfer
    case (size_in)
      HSIZE_BYTE:
      begin
        shamt = {lane_in, 3'h0};
        cont_mask = CONT_MASK_BYTE;
      end
      HSIZE_HALF:
      begin
        shamt = {lane_in[LANE_HI], 4'h0};
        cont_mask = CONT_MASK_HALF;
      end
      default:
      begin
        shamt = 5'h00;
        cont_mask = CONT_MASK_WORD;
      end
    endcase
    cont_rd = rdata_in >> shamt;
    // Width-minus-one plus one ones, moved up to the lsb
    ones = (17'h00001 << ({1'b0, wm1_in} + 5'h01)) - 17'h00001;
    wide_mask = {31'h00000000, ones} << lsb_in;
    // Field bits past the container are dropped
    mask = wide_mask[31:0] & cont_mask;
    // Write data inside the mask, read data outside
    merged = (cont_rd & ~mask) | (wdata_in & mask);
    // Replicate so the slave finds the container on its own lane
    case (size_in)
      HSIZE_BYTE: merged_out = {4{merged[7:0]}};
      HSIZE_HALF: merged_out = {2{merged[15:0]}};
      default: merged_out = merged;
    endcase
  end

endmodule : dbi_merge

`default_nettype wire

// ---- testbench/dbi_slave_model.sv ----
// Purpose: memory slave behind the bridge
// Assumes: one transfer at a time, wait count set by the bench
// Notes: read data is a toggling pattern outside the completing read cycle
`timescale 1ns/1ps
`default_nettype none
module dbi_slave_model
(
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic [3:0] waits_in,
  output logic [31:0] hrdata_out,
  output logic hready_out,
  output int nxfer_out,
  output logic [31:0] addr_out,
  output logic [1:0] dir_out
);
  logic [31:0] mem [16]; // Word store
  logic [31:0] noise_reg; // Filler while not driving
  logic ph_reg; // Data phase open
  logic [3:0] cnt_reg; // Wait cycles left
  logic [2:0] sz_reg; // Captured size
  // Real data only in the completing read cycle
  assign hrdata_out = (ph_reg && hready_out && !dir_out[0]) ? mem[addr_out[5:2]] : noise_reg;
  initial for (int i = 0; i < 16; i++) mem[i] = 32'h0;
  // Address phase, waits and write commit
  always @(posedge clk_in)
  begin
    noise_reg <= ~noise_reg ^ 32'h5a5a0001;
    if (srst_in)
    begin
      ph_reg <= 1'b0;
      hready_out <= 1'b1;
      nxfer_out <= 0;
      addr_out <= 32'h0;
      dir_out <= 2'h0;
      noise_reg <= 32'h0;
    end
    else
    begin
      // Commit written lanes at the end of the data phase
      if (ph_reg && hready_out && dir_out[0])
        case (sz_reg)
          3'h0: mem[addr_out[5:2]][8*addr_out[1:0] +: 8] <= hwdata_in[8*addr_out[1:0] +: 8];
          3'h1: mem[addr_out[5:2]][16*addr_out[1] +: 16] <= hwdata_in[16*addr_out[1] +: 16];
          default: mem[addr_out[5:2]] <= hwdata_in;
        endcase
      if (htrans_in[1] && hready_out)
      begin
        ph_reg <= 1'b1;
        sz_reg <= hsize_in;
        addr_out <= haddr_in;
        dir_out <= {dir_out[0], hwrite_in};
        nxfer_out <= nxfer_out + 1;
        cnt_reg <= waits_in;
        hready_out <= (waits_in == 4'h0);
      end
      else if (ph_reg && hready_out)
        ph_reg <= 1'b0;
      else if (ph_reg)
      begin
        cnt_reg <= cnt_reg - 4'h1;
        hready_out <= (cnt_reg == 4'h1);
      end
    end
  end
endmodule : dbi_slave_model
`default_nettype wire

// ---- testbench/dbi_bridge_tb_top.sv ----
// Purpose: self-checking bench for the field insert bridge
// Assumes: bench acts as bus master, model as slave
// Notes: read-back of each insert is checked through a queue
`timescale 1ns/1ps
`default_nettype none
module dbi_bridge_tb_top;
  import dbi_pkg::*;
  logic clk = 1'b0; // Bus clock
  logic srst = 1'b1; // Reset
  logic ce = 1'b1; // Clock enable
  logic [31:0] haddr = 32'h0, hwdata = 32'h0; // Master request
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h0;
  logic [3:0] hprot = 4'h0, waits = 4'h0;
  logic [31:0] m_rdata, s_addr, s_wdata, s_rdata, mod_addr; // Observed
  logic m_rdy, m_resp, s_write, s_ready;
  logic [1:0] s_trans, mod_dir;
  logic [2:0] s_size;
  logic [3:0] s_prot;
  int nxfer, n_checks = 0, n_mismatch = 0, n0;
  logic [31:0] expq [$]; // Expected read data
  logic rd_pend = 1'b0, rdy_prev = 1'b1;
  logic s_err = 1'b0; // Slave error answer
  logic [31:0] rnd = 32'h00013974, old, d, a;
  logic [4:0] b;
  logic [3:0] w;
  logic [1:0] ln;
  logic [2:0] sz;
  always #50 clk = ~clk;
  dbi_bridge dut_u (.CLOCK_IN(clk), .SRST_IN(srst), .CE_IN(ce), .M_HADDR_IN(haddr),
    .M_HTRANS_IN(htrans), .M_HWRITE_IN(hwrite), .M_HSIZE_IN(hsize), .M_HPROT_IN(hprot),
    .M_HWDATA_IN(hwdata), .M_HREADY_IN(m_rdy), .M_HRDATA_OUT(m_rdata), .M_HREADYOUT_OUT(m_rdy),
    .M_HRESP_OUT(m_resp), .S_HADDR_OUT(s_addr), .S_HTRANS_OUT(s_trans), .S_HWRITE_OUT(s_write),
    .S_HSIZE_OUT(s_size), .S_HPROT_OUT(s_prot), .S_HWDATA_OUT(s_wdata), .S_HRDATA_IN(s_rdata),
    .S_HREADY_IN(s_ready), .S_HRESP_IN(s_err));
  dbi_slave_model slave_u (.clk_in(clk), .srst_in(srst), .haddr_in(s_addr), .htrans_in(s_trans),
    .hwrite_in(s_write), .hsize_in(s_size), .hwdata_in(s_wdata), .waits_in(waits),
    .hrdata_out(s_rdata), .hready_out(s_ready), .nxfer_out(nxfer), .addr_out(mod_addr),
    .dir_out(mod_dir));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // Expected memory word after an insert
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] dv,
    input logic [4:0] bv, input logic [3:0] wv, input logic [2:0] s, input logic [1:0] l);
    logic [63:0] m;
    logic [31:0] c, r;
    int sh;
    m = ((64'h1 << (int'(wv) + 1)) - 64'h1) << bv;
    sh = (s == HSIZE_WORD) ? 0 : 8 * l;
    c = (s == HSIZE_BYTE) ? CONT_MASK_BYTE : (s == HSIZE_HALF) ? CONT_MASK_HALF : CONT_MASK_WORD;
    r = (o >> sh) & c;
    r = ((r & ~m[31:0]) | (dv & m[31:0])) & c;
    return (o & ~(c << sh)) | (r << sh);
  endfunction : merge
  task automatic chk(input logic [95:0] got, input logic [95:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done
  // One master transfer; checks slave request and stall length
  task automatic op(input logic [31:0] ad, input logic wr, input logic [2:0] s,
    input logic [31:0] dv, input logic ins, input int lows);
    int n;
    @(negedge clk);
    haddr = ad;
    htrans = HTRANS_NONSEQ;
    hwrite = wr;
    hsize = s;
    hprot = rnd[3:0];
    @(negedge clk);
    htrans = HTRANS_IDLE;
    hwdata = dv;
    chk({s_trans, s_addr, s_write, s_size, s_prot}, {HTRANS_NONSEQ, ins ? ad & REAL_ADDR_MASK : ad,
      wr & !ins, s, hprot});
    n = 0;
    while (m_rdy !== 1'b1 && n < 50)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 50)
    begin
      n_mismatch++;
      test_done();
    end
    chk(n, lows);
  endtask : op
  task automatic rd(input logic [31:0] ad, input logic [31:0] exp);
    expq.push_back(exp);
    op(ad, 1'b0, HSIZE_WORD, 32'h0, 1'b0, 2 + int'(waits));
  endtask : rd
  // Note whether the taken transfer is a read
  always @(posedge clk)
    if (m_rdy === 1'b1 && htrans[1] === 1'b1)
      rd_pend = !hwrite;
  // Compare read data as each read completes
  always @(negedge clk)
  begin
    if (rd_pend && !rdy_prev && m_rdy === 1'b1 && expq.size() > 0)
      chk(m_rdata, expq.pop_front());
    rdy_prev = m_rdy;
  end
  initial
  begin
    repeat (5) @(negedge clk);
    srst = 1'b0;
    chk({m_rdy, m_resp, m_rdata, s_trans}, {1'b1, 1'b0, WORD_ZERO, HTRANS_IDLE});
    $display("test reset done");
    // Plain traffic with growing slave waits
    for (int i = 0; i < 4; i++)
    begin
      waits = 4'(i);
      rnd = lfsr(rnd);
      op(32'h20000000 | (i << 2), 1'b1, HSIZE_WORD, rnd, 1'b0, 2 + i);
      rd(32'h20000000 | (i << 2), rnd);
    end
    $display("test plain done");
    // Inserts over all sizes, both regions, random fields and waits
    for (int k = 0; k < 30; k++)
    begin
      rnd = lfsr(rnd);
      old = rnd;
      rnd = lfsr(rnd);
      sz = 3'(k % 3);
      b = rnd[4:0];
      w = rnd[8:5];
      ln = (sz == HSIZE_BYTE) ? rnd[10:9] : (sz == HSIZE_HALF) ? {rnd[10], 1'b0} : 2'h0;
      waits = {2'h0, rnd[12:11]};
      if (k == 0)
      begin
        b = 5'h0;
        w = 4'h0;
      end
      if (k == 3)
      begin
        b = 5'h7;
        w = 4'h2;
      end
      rnd = lfsr(rnd);
      d = (sz == HSIZE_BYTE) ? {4{rnd[7:0]}} : (sz == HSIZE_HALF) ? {2{rnd[15:0]}} : rnd;
      a = {1'b0, k[0] ? REGION_PERIPH : REGION_SRAM_U, 1'b1, b, w, 13'h0, 4'(k), ln};
      op({a[31:29], 23'h0, 4'(k), 2'h0}, 1'b1, HSIZE_WORD, old, 1'b0, 2 + int'(waits));
      n0 = nxfer;
      op(a, 1'b1, sz, d, 1'b1, 4 + 2 * int'(waits));
      chk({nxfer - n0, mod_dir, mod_addr}, {32'h2, 2'h1, a & REAL_ADDR_MASK});
      rd({a[31:29], 23'h0, 4'(k), 2'h0}, merge(old, d, b, w, sz, ln));
    end
    $display("test insert done");
    // Slave error on the insert read: no write-back, two-cycle error answer
    s_err = 1'b1;
    n0 = nxfer;
    op(a, 1'b1, sz, d, 1'b1, 3 + int'(waits));
    chk({m_resp, nxfer - n0}, {1'b1, 32'h1});
    s_err = 1'b0;
    rd({a[31:29], 23'h0, a[5:2], 2'h0}, merge(old, d, b, w, sz, ln));
    $display("test error done");
    // Writes that are not inserts go through untouched
    waits = 4'h1;
    rnd = lfsr(rnd);
    op(32'h10000010, 1'b1, HSIZE_WORD, rnd, 1'b0, 3);
    rd(32'h00000010, rnd);
    rnd = lfsr(rnd);
    op(32'h24000014, 1'b1, HSIZE_WORD, rnd, 1'b0, 3);
    rd(32'h20000014, rnd);
    // Clock enable low: a request standing meanwhile is not taken
    @(negedge clk);
    ce = 1'b0;
    n0 = nxfer;
    haddr = 32'h20000000;
    hwrite = 1'b0;
    htrans = HTRANS_NONSEQ;
    repeat (3) @(negedge clk);
    chk({m_rdy, s_trans, nxfer - n0}, {1'b1, HTRANS_IDLE, 32'h0});
    htrans = HTRANS_IDLE;
    ce = 1'b1;
    $display("test forward done");
    repeat (2) @(negedge clk);
    test_done();
  end
endmodule : dbi_bridge_tb_top
`default_nettype wire
